// file: eeprom_ctrl_pkg.sv
// package for the eeprom program/erase control block
// assumes one 125 MHz clock and a byte-wide register port
package eeprom_ctrl_pkg;
    // register map
    localparam logic [7:0] CTRL_OFFSET = 8'h1c;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // control register bit positions
    localparam int BIT_PGM = 0;
    localparam int BIT_RC = 1;
    localparam int BIT_LATCH = 2;
    localparam int BIT_ER0 = 3;
    localparam int BIT_ER1 = 4;
    localparam int BIT_CHARGE_PUMP_ENABLE = 6;
    // writable bits; bits 7 and 5 read zero
    localparam logic [7:0] CTRL_WMASK = 8'h5e;
    // array geometry
    localparam int ARRAY_BYTES = 256;
    localparam int BLOCK_SHIFT = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hff;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [7:0] ARRAY_BASE_HI = 8'h02;

    typedef enum logic [1:0] {
        MODE_PROGRAM = 2'b00,
        MODE_BYTE_ERASE = 2'b01,
        MODE_BLOCK_ERASE = 2'b10,
        MODE_BULK_ERASE = 2'b11
    } erase_mode_t;

    // cpu-side access to the eeprom array space
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } array_req_t;
endpackage : eeprom_ctrl_pkg

// file: eeprom_program_erase_control.sv
// eeprom program/erase control register with a flip-flop model of the array
// assumes reg port and array port are driven synchronously to clk
//
// How it works
// R1 - erase select field picks program, byte, block or bulk erase
// R2 - erase select bits read/write, cleared by reset
// R3 - block erase clears the aligned 64-byte block of the latched address
// R4 - bulk erase clears all 256 bytes regardless of latched address
// R5 - byte erase clears only the latched byte
// R6 - with latch set, array writes capture address and data
// R7 - with latch set and a write captured, array reads are blocked
// R8 - latch clear gives normal reads; latch bit read/write, reset zero
// R9 - clock source bit picks rc oscillator or cpu clock; reset zero
// R10 - software picks rc oscillator below 1.5 MHz and waits settle time
// R11 - program power bit applies pump power to the array
// R12 - program power bit writable only while latch is one
// R13 - software program sequence: latch, pump, mode 00, write, power
// R14 - software erase sequence: latch, pump, mode, write, power
// R15 - software ends: clear power, wait fall time, clear latch and pump
// R16 - pump enable powers the pump; voltage reaches array only with power
// R17 - erased byte reads ff; programming only clears bits
// R18 - erase ignores captured data; only address selects target
`timescale 1ns/100ps
`default_nettype none
module eeprom_program_erase_control (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire eeprom_ctrl_pkg::array_req_t array_req,
    output logic [7:0] array_rdata,
    output logic array_rd_blocked,
    output logic pump_on,
    output logic array_power_on,
    output logic array_clk_sel_rc
);
    // control register, its next value and the power history
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic pgm_q;

    // address and data latched by an array write
    logic captured_q;
    logic [7:0] cap_addr_q;
    logic [7:0] cap_data_q;

    // array storage and the bytes an operation reaches
    logic [7:0] mem_q [0:eeprom_ctrl_pkg::ARRAY_BYTES-1];
    logic [eeprom_ctrl_pkg::ARRAY_BYTES-1:0] target_hit;

    // registered outputs
    logic [7:0] reg_rdata_q;
    logic [7:0] array_rdata_q;
    logic blocked_q;
    logic pump_q;
    logic power_q;
    logic rc_q;

    // next values of the level outputs
    logic pump_d;
    logic power_d;
    logic rc_d;

    // decoded strobes and control fields
    logic ctrl_wr;
    logic ctrl_rd;
    logic latch_on;
    logic pump_en;
    logic power_bit;
    logic latched_wr;
    logic read_inhibit;
    logic array_rd_ok;
    logic array_rd_stop;
    logic start_pulse;
    logic [7:0] array_byte;
    eeprom_ctrl_pkg::erase_mode_t mode;

    // true when a register access hits the control register
    function automatic logic ctrl_hit(
        input logic [7:0] addr
    );
        ctrl_hit = (addr == eeprom_ctrl_pkg::CTRL_OFFSET);
    endfunction : ctrl_hit

    // which of the four blocks an array address falls in
    function automatic logic [1:0] block_of(
        input logic [7:0] addr
    );
        block_of = 2'(addr >> eeprom_ctrl_pkg::BLOCK_SHIFT);
    endfunction : block_of

    // erase mode held in a control value
    function automatic eeprom_ctrl_pkg::erase_mode_t mode_of(
        input logic [7:0] ctrl
    );
        mode_of = eeprom_ctrl_pkg::erase_mode_t'({ctrl[eeprom_ctrl_pkg::BIT_ER1],
                                                  ctrl[eeprom_ctrl_pkg::BIT_ER0]});
    endfunction : mode_of

    // pump runs with its enable or with power
    function automatic logic pump_level(
        input logic [7:0] ctrl
    );
        pump_level = ctrl[eeprom_ctrl_pkg::BIT_CHARGE_PUMP_ENABLE] | ctrl[eeprom_ctrl_pkg::BIT_PGM];
    endfunction : pump_level

    // control value as software reads it; unused bits read zero
    function automatic logic [7:0] ctrl_view(
        input logic [7:0] ctrl
    );
        ctrl_view = ctrl & eeprom_ctrl_pkg::CTRL_WMASK;
        ctrl_view[eeprom_ctrl_pkg::BIT_PGM] = ctrl[eeprom_ctrl_pkg::BIT_PGM];
    endfunction : ctrl_view

    // true when the array byte at idx falls in the target
    function automatic logic in_target(
        input eeprom_ctrl_pkg::erase_mode_t m,
        input logic [7:0] idx,
        input logic [7:0] a
    );
        unique case (m)
            eeprom_ctrl_pkg::MODE_PROGRAM: begin
                in_target = (idx == a);
            end
            eeprom_ctrl_pkg::MODE_BYTE_ERASE: begin
                in_target = (idx == a); // see R5
            end
            eeprom_ctrl_pkg::MODE_BLOCK_ERASE: begin
                in_target = (block_of(idx) == block_of(a)); // see R3
            end
            eeprom_ctrl_pkg::MODE_BULK_ERASE: begin
                in_target = 1'b1; // see R4
            end
        endcase
    endfunction : in_target

    // value a target byte takes when the operation is applied
    function automatic logic [7:0] next_byte(
        input eeprom_ctrl_pkg::erase_mode_t m,
        input logic [7:0] old,
        input logic [7:0] data
    );
        if (m == eeprom_ctrl_pkg::MODE_PROGRAM) begin
            next_byte = old & data; // see R17
        end else begin
            next_byte = eeprom_ctrl_pkg::ERASED_BYTE; // see R17, R18
        end
    endfunction : next_byte

    // register strobes and control fields
    assign ctrl_wr = reg_wr && ctrl_hit(reg_addr);
    assign ctrl_rd = reg_rd && ctrl_hit(reg_addr);
    assign latch_on = ctrl_q[eeprom_ctrl_pkg::BIT_LATCH];
    assign pump_en = ctrl_q[eeprom_ctrl_pkg::BIT_CHARGE_PUMP_ENABLE];
    assign power_bit = ctrl_q[eeprom_ctrl_pkg::BIT_PGM];
    assign mode = mode_of(ctrl_q); // see R1

    // array side strobes; reads inhibited once a latched write was taken
    assign latched_wr = latch_on && array_req.wr; // see R6
    assign read_inhibit = latch_on && captured_q; // see R7
    assign array_rd_ok = array_req.rd && !read_inhibit; // see R8
    assign array_rd_stop = array_req.rd && read_inhibit; // see R7
    assign array_byte = mem_q[array_req.addr]; // see R8

    // next control value; power bit only takes writes while latch is one
    always_comb begin
        ctrl_d = ctrl_q;
        if (ctrl_wr) begin
            ctrl_d = eeprom_ctrl_pkg::CTRL_RESET;
            ctrl_d[eeprom_ctrl_pkg::BIT_CHARGE_PUMP_ENABLE] = reg_wdata[eeprom_ctrl_pkg::BIT_CHARGE_PUMP_ENABLE]; // see R16
            ctrl_d[eeprom_ctrl_pkg::BIT_ER1] = reg_wdata[eeprom_ctrl_pkg::BIT_ER1]; // see R2
            ctrl_d[eeprom_ctrl_pkg::BIT_ER0] = reg_wdata[eeprom_ctrl_pkg::BIT_ER0]; // see R2
            ctrl_d[eeprom_ctrl_pkg::BIT_LATCH] = reg_wdata[eeprom_ctrl_pkg::BIT_LATCH]; // see R8
            ctrl_d[eeprom_ctrl_pkg::BIT_RC] = reg_wdata[eeprom_ctrl_pkg::BIT_RC]; // see R9
            if (latch_on) begin
                ctrl_d[eeprom_ctrl_pkg::BIT_PGM] = reg_wdata[eeprom_ctrl_pkg::BIT_PGM]; // see R12
            end else begin
                ctrl_d[eeprom_ctrl_pkg::BIT_PGM] = 1'b0; // see R12
            end
        end
    end

    // level outputs follow the next control value
    assign pump_d = pump_level(ctrl_d); // see R11, R16
    assign power_d = ctrl_d[eeprom_ctrl_pkg::BIT_PGM]; // see R11
    assign rc_d = ctrl_d[eeprom_ctrl_pkg::BIT_RC]; // see R9

    // program or erase is applied once, on the rise of the power bit while a write is captured and the pump is enabled
    assign start_pulse = power_bit
                         && !pgm_q
                         && captured_q
                         && pump_en; // see R11, R16

    // control register
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_q <= eeprom_ctrl_pkg::CTRL_RESET; // see R2
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // power bit one cycle back, for the rise
    always_ff @(posedge clk) begin
        if (reset) begin
            pgm_q <= 1'b0;
        end else begin
            pgm_q <= power_bit;
        end
    end

    // capture flag, dropped whenever the latch is clear
    always_ff @(posedge clk) begin
        if (reset) begin
            captured_q <= 1'b0;
        end else if (!latch_on) begin
            captured_q <= 1'b0;
        end else if (array_req.wr) begin
            captured_q <= 1'b1; // see R6
        end else begin
            captured_q <= captured_q;
        end
    end

    // captured address
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_addr_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end else if (latched_wr) begin
            cap_addr_q <= array_req.addr; // see R6
        end else begin
            cap_addr_q <= cap_addr_q;
        end
    end

    // captured data
    always_ff @(posedge clk) begin
        if (reset) begin
            cap_data_q <= eeprom_ctrl_pkg::ERASED_BYTE;
        end else if (latched_wr) begin
            cap_data_q <= array_req.wdata; // see R6
        end else begin
            cap_data_q <= cap_data_q;
        end
    end

    // bytes reached by the pending operation
    always_comb begin
        for (int i = 0; i < eeprom_ctrl_pkg::ARRAY_BYTES; i++) begin
            target_hit[i] = in_target(mode, 8'(i), cap_addr_q);
        end
    end

    // array contents: erase to ff, program clears bits only
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < eeprom_ctrl_pkg::ARRAY_BYTES; i++) begin
                mem_q[i] <= eeprom_ctrl_pkg::ERASED_BYTE;
            end
        end else begin
            for (int i = 0; i < eeprom_ctrl_pkg::ARRAY_BYTES; i++) begin
                if (start_pulse && target_hit[i]) begin
                    mem_q[i] <= next_byte(mode, mem_q[i], cap_data_q);
                end
            end
        end
    end

    // register read port, data one cycle after the strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            reg_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end else if (ctrl_rd) begin
            reg_rdata_q <= ctrl_view(ctrl_q); // see R2, R8
        end else if (reg_rd) begin
            reg_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end else begin
            reg_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end
    end

    // array read data, zero when idle or inhibited
    always_ff @(posedge clk) begin
        if (reset) begin
            array_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end else if (array_rd_ok) begin
            array_rdata_q <= array_byte; // see R8
        end else if (array_rd_stop) begin
            array_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE; // see R7
        end else begin
            array_rdata_q <= eeprom_ctrl_pkg::ZERO_BYTE;
        end
    end

    // array read inhibit flag
    always_ff @(posedge clk) begin
        if (reset) begin
            blocked_q <= 1'b0;
        end else if (array_rd_stop) begin
            blocked_q <= 1'b1; // see R7
        end else if (array_rd_ok) begin
            blocked_q <= 1'b0;
        end else begin
            blocked_q <= 1'b0;
        end
    end

    // charge pump level
    always_ff @(posedge clk) begin
        if (reset) begin
            pump_q <= 1'b0;
        end else begin
            pump_q <= pump_d; // see R16
        end
    end

    // programming power level
    always_ff @(posedge clk) begin
        if (reset) begin
            power_q <= 1'b0;
        end else begin
            power_q <= power_d; // see R11
        end
    end

    // array clock source
    always_ff @(posedge clk) begin
        if (reset) begin
            rc_q <= 1'b0;
        end else begin
            rc_q <= rc_d; // see R9
        end
    end

    // outputs straight from their flip-flops
    assign reg_rdata = reg_rdata_q;
    assign array_rdata = array_rdata_q;
    assign array_rd_blocked = blocked_q;
    assign pump_on = pump_q;
    assign array_power_on = power_q;
    assign array_clk_sel_rc = rc_q;
endmodule : eeprom_program_erase_control
`default_nettype wire

// file: eeprom_ctrl_props.sv
// assertions on the ports of the eeprom program/erase control
// assumes one clock and a synchronous active-high reset
`timescale 1ns/100ps
`default_nettype none
module eeprom_ctrl_checker (
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire eeprom_ctrl_pkg::array_req_t array_req,
    input wire logic [7:0] array_rdata,
    input wire logic array_rd_blocked,
    input wire logic pump_on,
    input wire logic array_power_on,
    input wire logic array_clk_sel_rc
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire logic ctl_wr = reg_wr && reg_addr == 8'h1c;
    property p_pwr_pump; array_power_on |-> pump_on; endproperty
    a_pwr_pump: assert property (p_pwr_pump) else $error("power without pump");
    property p_pwr_set; $rose(array_power_on) |-> $past(ctl_wr && reg_wdata[0]); endproperty
    a_pwr_set: assert property (p_pwr_set) else $error("power rose without write");
    property p_pwr_clr; ctl_wr && !reg_wdata[0] |=> !array_power_on; endproperty
    a_pwr_clr: assert property (p_pwr_clr) else $error("power not removed");
    property p_rst; $fell(reset) |-> !pump_on && !array_power_on && !array_clk_sel_rc; endproperty
    a_rst: assert property (p_rst) else $error("outputs not clear after reset");
    property p_blk; array_rd_blocked |-> array_rdata == 8'h00; endproperty
    a_blk: assert property (p_blk) else $error("blocked read shows data");
    property p_idle; !array_req.rd |=> !array_rd_blocked && array_rdata == 8'h00; endproperty
    a_idle: assert property (p_idle) else $error("array answer without read");
    property p_rc; ctl_wr |=> array_clk_sel_rc == $past(reg_wdata[1]); endproperty
    a_rc: assert property (p_rc) else $error("clock source wrong");
    property p_pump; ctl_wr |=> pump_on == ($past(reg_wdata[6]) || array_power_on); endproperty
    a_pump: assert property (p_pump) else $error("pump state wrong");
endmodule : eeprom_ctrl_checker
bind eeprom_program_erase_control eeprom_ctrl_checker eeprom_ctrl_checker_inst (.clk, .reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .array_req, .array_rdata, .array_rd_blocked, .pump_on,
    .array_power_on, .array_clk_sel_rc);
`default_nettype wire

// file: pump_model.sv
// far-side model of the charge pump feeding the array
// assumes pump and power levels come from the control block
`timescale 1ns/100ps
`default_nettype none
module pump_model (
    input wire logic clk,
    input wire logic pump_on,
    input wire logic array_power_on,
    output logic hv_ready
);
    always_ff @(posedge clk) begin
        hv_ready <= pump_on && array_power_on;
    end
endmodule : pump_model
`default_nettype wire

// file: tb.sv
// self-checking bench for the eeprom program/erase control
// assumes the design, its checker and the pump model beside it
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic clk = 0, reset = 1, reg_wr = 0, reg_rd = 0, pr = 0, pa = 0, pw = 0, pw2 = 0, hv;
    logic [7:0] ctl = 0;
    logic [3:0] qo [$];
    logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, array_rdata, mem [256];
    logic array_rd_blocked, pump_on, array_power_on, array_clk_sel_rc;
    eeprom_ctrl_pkg::array_req_t array_req = '0;
    logic [8:0] q [$];
    int fails = 0, comparisons = 0;
    always #4 clk = ~clk;
    eeprom_program_erase_control eeprom_program_erase_control_inst (.clk, .reset, .reg_addr, .reg_wdata,
        .reg_wr, .reg_rd, .reg_rdata, .array_req, .array_rdata, .array_rd_blocked, .pump_on, .array_power_on,
        .array_clk_sel_rc);
    pump_model pump_model_inst (.clk, .pump_on, .array_power_on, .hv_ready(hv));
    task conclude;
        if (fails == 0 && comparisons > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    // kind 0 reg write, 1 reg read, 2 array write, 3 array read
    task op(input logic [1:0] k, input logic [7:0] a, d, input logic [8:0] e);
        if (k[0]) q.push_back(e);
        if (k == 2'd0 && a == 8'h1c) begin
            ctl = (d & 8'h5e) | {7'd0, ctl[2] & d[0]};
            qo.push_back({ctl[0], ctl[6] | ctl[0], ctl[0], ctl[1]});
        end
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= k == 2'd0;
        reg_rd <= k == 2'd1;
        array_req <= {k == 2'd2, k == 2'd3, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        array_req <= '0;
    endtask : op
    task chk(input string n, input logic [8:0] got);
        logic [8:0] e;
        e = q.pop_front();
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, got);
        end
    endtask : chk
    task chk_out(input string n, input logic [3:0] got);
        logic [3:0] e;
        e = qo.pop_front();
        comparisons++;
        if (got !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", n, e, got);
        end
    endtask : chk_out
    always @(posedge clk) begin
        pr <= reg_rd;
        pa <= array_req.rd;
        pw <= reg_wr && reg_addr == 8'h1c;
        pw2 <= pw;
    end
    always @(negedge clk) begin
        if (pr) chk("reg_rdata", {1'b0, reg_rdata});
        if (pa) chk("array_read", {array_rd_blocked, array_rdata});
        if (pw2) chk_out("outputs", {hv, pump_on, array_power_on, array_clk_sel_rc});
    end
    task prog(input logic [7:0] a, d, input logic [1:0] m);
        logic [7:0] c;
        c = {3'b010, m, 1'b1, m[0], 1'b0};
        op(0, 8'h1c, c, 0);
        op(2, a, d, 0);
        op(3, a, 0, 9'h100);
        op(0, 8'h1c, c | 8'h01, 0);
        op(0, 8'h1c, c, 0);
        op(0, 8'h1c, 8'h00, 0);
        for (int i = 0; i < 256; i++)
            if (m == 2'd3 || (m == 2'd2 && i[7:6] == a[7:6]) || (m == 2'd1 && i == a)) mem[i] = 8'hff;
        if (m == 2'd0) mem[a] = mem[a] & d;
    endtask : prog
    initial begin
        logic [7:0] a;
        void'($urandom(32'hdb61));
        for (int i = 0; i < 256; i++) mem[i] = 8'hff;
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        op(1, 8'h1c, 0, 9'h000);
        op(0, 8'h1c, 8'hff, 0);
        op(1, 8'h1c, 0, 9'h05e);
        op(0, 8'h1c, 8'h5f, 0);
        op(1, 8'h1c, 0, 9'h05f);
        op(0, 8'h1c, 8'h00, 0);
        op(1, 8'h1d, 0, 9'h000);
        for (int m = 0; m < 4; m++) begin
            a = 8'($urandom);
            prog(a, 8'($urandom), 0);
            prog(a ^ 8'h01, 8'($urandom), 0);
            prog(a ^ 8'h40, 8'($urandom), 0);
            prog(a, 8'($urandom), m[1:0]);
            op(3, a, 0, {1'b0, mem[a]});
            op(3, a ^ 8'h01, 0, {1'b0, mem[a ^ 8'h01]});
            op(3, a ^ 8'h40, 0, {1'b0, mem[a ^ 8'h40]});
        end
        conclude;
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        conclude;
    end
endmodule : tb
`default_nettype wire
